// ---- arc_host.sv ----
// Purpose: Host model on the control port of the register bank
// Assumes: Requests change at the falling edge, one request per call
// Notes:   Write data idles inverted so a stale word never looks valid
`timescale 1ns/1ps
module arc_host
	import arc_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic [ARC_DATA_W-1:0] rd_data,
	input  wire logic                  rd_valid,
	output logic                       wr_en,
	output logic                       rd_en,
	output logic      [ARC_ADDR_W-1:0] addr,
	output logic      [ARC_DATA_W-1:0] wr_data
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wr_data = 32'h0000_0000;
	end
	task automatic write(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		v = d;
		// Never point the program past its last instruction
		if (a == ARC_OFS_START && v[11:0] > ARC_PC_LAST)
			v[11:0] = ARC_PC_LAST;
		@(negedge core_clk);
		wr_en = 1'b1;
		addr = a;
		wr_data = v;
		@(negedge core_clk);
		wr_en = 1'b0;
		wr_data = ~v;
	endtask
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic ok);
		@(negedge core_clk);
		rd_en = 1'b1;
		addr = a;
		@(negedge core_clk);
		rd_en = 1'b0;
		d = rd_data;
		ok = rd_valid;
	endtask
endmodule

// ---- arc_input_decode.sv ----
// Purpose: Decode of one 4-bit analog input select field
// Assumes: Code 0 mute, 1..10 lines, 11 DAC, 12..15 reserved
// Notes:   Reserved codes select nothing, which leaves the path silent
`timescale 1ns/1ps
module arc_input_decode
	import arc_pkg::*;
(
	input  wire logic [3:0]           sel_code,
	output logic      [ARC_LINES-1:0] line_onehot,
	output logic                      mute,
	output logic                      dac_sel,
	output logic                      reserved
);
	genvar g;
	generate
		for (g = 0; g < ARC_LINES; g++) begin : g_line
			assign line_onehot[g] = (sel_code == 4'(g + 1));
		end
	endgenerate
	assign mute     = (sel_code == ARC_SEL_MUTE);
	assign dac_sel  = (sel_code == ARC_SEL_DAC);
	assign reserved = (sel_code > ARC_SEL_DAC);
endmodule

// ---- arc_pkg.sv ----
// Purpose: Constants for the audio routing control register bank
// Assumes: 32-bit registers addressed by 8-bit subaddress
// Notes:   Offsets are the subaddresses of the control port
package arc_pkg;
	localparam int          ARC_DATA_W        = 32;
	localparam int          ARC_ADDR_W        = 8;
	localparam int          ARC_PC_W          = 12;
	localparam logic [7:0]  ARC_OFS_AMUX      = 8'h12;
	localparam logic [7:0]  ARC_OFS_TXCS      = 8'h16;
	localparam logic [7:0]  ARC_OFS_DITHER    = 8'h1D;
	localparam logic [7:0]  ARC_OFS_START     = 8'h1E;
	localparam logic [31:0] ARC_MASK_AMUX     = 32'h0F00_000F;
	localparam logic [31:0] ARC_MASK_TXCS     = 32'hFFFF_FF03;
	localparam logic [31:0] ARC_MASK_DITHER   = 32'h0000_0001;
	localparam logic [31:0] ARC_MASK_START    = 32'h0000_0FFF;
	localparam logic [31:0] ARC_RST_AMUX      = 32'h0000_0000;
	localparam logic [31:0] ARC_RST_TXCS      = 32'h0000_0000;
	localparam logic [31:0] ARC_RST_DITHER    = 32'h0000_0000;
	localparam logic [31:0] ARC_RST_START     = 32'h0000_0000;
	localparam int          ARC_AMUX_HI_LSB   = 24;
	localparam int          ARC_AMUX_LO_LSB   = 0;
	localparam logic [3:0]  ARC_SEL_MUTE      = 4'h0;
	localparam logic [3:0]  ARC_SEL_LAST_LINE = 4'hA;
	localparam logic [3:0]  ARC_SEL_DAC       = 4'hB;
	localparam int          ARC_LINES         = 10;
	localparam int          ARC_COPY_BIT      = 31;
	localparam int          ARC_EMPH_BIT      = 30;
	localparam int          ARC_CLK_ACC_LSB   = 28;
	localparam int          ARC_WLEN_LSB      = 24;
	localparam int          ARC_RATE_LSB      = 22;
	localparam int          ARC_LVALID_BIT    = 21;
	localparam int          ARC_RVALID_BIT    = 20;
	localparam int          ARC_SRCN_LSB      = 16;
	localparam int          ARC_CAT_LSB       = 9;
	localparam int          ARC_GEN_BIT       = 8;
	localparam int          ARC_ROUTE_HI_BIT  = 1;
	localparam int          ARC_ROUTE_LO_BIT  = 0;
	localparam int          ARC_DITHER_BIT    = 0;
	localparam logic [11:0] ARC_PC_LAST       = 12'hCFF;
	typedef enum logic [1:0] {
		ARC_ROUTE_SERIAL2,
		ARC_ROUTE_TX,
		ARC_ROUTE_DIN
	} arc_route_type;
endpackage

// ---- arc_regs.sv ----
// Purpose: Audio routing control register bank with program restart pointer
// Assumes: Host write/read strobes are synchronous single-cycle requests
// Notes:   Read data is registered and valid the cycle after rd_en
`timescale 1ns/1ps
module arc_regs
	import arc_pkg::*;
#(
	parameter int PC_W = ARC_PC_W
)
(
	input  wire logic                    core_clk,
	input  wire logic                    reset,
	input  wire logic                    wr_en,
	input  wire logic                    rd_en,
	input  wire logic [ARC_ADDR_W-1:0]   addr,
	input  wire logic [ARC_DATA_W-1:0]   wr_data,
	output logic      [ARC_DATA_W-1:0]   rd_data,
	output logic                         rd_valid,
	input  wire logic                    sample_start,
	input  wire logic                    step,
	output logic      [PC_W-1:0]         dsp_pc,
	output logic      [ARC_LINES-1:0]    hi_line_sel,
	output logic                         hi_mute,
	output logic                         hi_dac_sel,
	output logic      [ARC_LINES-1:0]    lo_line_sel,
	output logic                         lo_mute,
	output logic                         lo_dac_sel,
	output logic                         copy_permit,
	output logic                         emphasis_flag,
	output logic      [1:0]              clock_accuracy_field,
	output logic      [3:0]              sample_length_field,
	output logic      [1:0]              sample_rate_field,
	output logic                         left_valid_flag,
	output logic                         right_valid_flag,
	output logic      [3:0]              source_number_field,
	output logic      [6:0]              category_code,
	output logic                         generation_flag,
	output logic                         route_sel_hi,
	output logic                         route_sel_lo,
	output arc_route_type                route_mode,
	output logic                         dither_on
);
	////////////////////////////////////////////////////////////////////////////
	logic [ARC_DATA_W-1:0] amux_r;
	logic [ARC_DATA_W-1:0] txcs_r;
	logic [ARC_DATA_W-1:0] dith_r;
	logic [ARC_DATA_W-1:0] start_r;
	logic [ARC_DATA_W-1:0] rd_data_r;
	logic [ARC_DATA_W-1:0] rd_data_nxt;
	logic                  rd_valid_r;
	logic [PC_W-1:0]       pc_r;
	logic [PC_W-1:0]       pc_nxt;
	wire                   hit_amux;
	wire                   hit_txcs;
	wire                   hit_dith;
	wire                   hit_start;
	wire                   hi_rsv;
	wire                   lo_rsv;

	assign hit_amux  = (addr == ARC_OFS_AMUX);
	assign hit_txcs  = (addr == ARC_OFS_TXCS);
	assign hit_dith  = (addr == ARC_OFS_DITHER);
	assign hit_start = (addr == ARC_OFS_START);

	// Masking on write keeps unused bits at zero so reads need no second mask
	always_ff @(posedge core_clk) begin
		if (reset) begin
			amux_r  <= ARC_RST_AMUX;
			txcs_r  <= ARC_RST_TXCS;
			dith_r  <= ARC_RST_DITHER;
			start_r <= ARC_RST_START;
		end else if (wr_en) begin
			if (hit_amux)
				amux_r <= wr_data & ARC_MASK_AMUX;
			if (hit_txcs)
				txcs_r <= wr_data & ARC_MASK_TXCS;
			if (hit_dith)
				dith_r <= wr_data & ARC_MASK_DITHER;
			if (hit_start)
				start_r <= wr_data & ARC_MASK_START;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Unmapped subaddresses read as zero
	assign rd_data_nxt = hit_amux  ? amux_r  :
	                     hit_txcs  ? txcs_r  :
	                     hit_dith  ? dith_r  :
	                     hit_start ? start_r : '0;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rd_data_r  <= '0;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_en;
			if (rd_en)
				rd_data_r <= rd_data_nxt;
		end
	end
	assign rd_data  = rd_data_r;
	assign rd_valid = rd_valid_r;

	////////////////////////////////////////////////////////////////////////////
	arc_input_decode u_dec_hi (
		.sel_code    (amux_r[ARC_AMUX_HI_LSB +: 4]),
		.line_onehot (hi_line_sel),
		.mute        (hi_mute),
		.dac_sel     (hi_dac_sel),
		.reserved    (hi_rsv)
	);
	arc_input_decode u_dec_lo (
		.sel_code    (amux_r[ARC_AMUX_LO_LSB +: 4]),
		.line_onehot (lo_line_sel),
		.mute        (lo_mute),
		.dac_sel     (lo_dac_sel),
		.reserved    (lo_rsv)
	);

	// Each code lands on exactly one of line, mute, DAC or reserved
	property p_hi_onehot;
		@(posedge core_clk) disable iff (reset)
		$onehot({hi_rsv, hi_dac_sel, hi_mute, hi_line_sel});
	endproperty
	a_hi_onehot: assert property (p_hi_onehot) else $error("high select clash");

	property p_lo_onehot;
		@(posedge core_clk) disable iff (reset)
		$onehot({lo_rsv, lo_dac_sel, lo_mute, lo_line_sel});
	endproperty
	a_lo_onehot: assert property (p_lo_onehot) else $error("low select clash");

	////////////////////////////////////////////////////////////////////////////
	assign copy_permit          = txcs_r[ARC_COPY_BIT];
	assign emphasis_flag        = txcs_r[ARC_EMPH_BIT];
	assign clock_accuracy_field = txcs_r[ARC_CLK_ACC_LSB +: 2];
	assign sample_length_field  = txcs_r[ARC_WLEN_LSB +: 4];
	// Bit 23 is b24, bit 22 is b25
	assign sample_rate_field    = txcs_r[ARC_RATE_LSB +: 2];
	assign left_valid_flag      = txcs_r[ARC_LVALID_BIT];
	assign right_valid_flag     = txcs_r[ARC_RVALID_BIT];
	assign source_number_field  = txcs_r[ARC_SRCN_LSB +: 4];
	// Bit 15 is b8 down to bit 9 as b14
	assign category_code        = txcs_r[ARC_CAT_LSB +: 7];
	assign generation_flag      = txcs_r[ARC_GEN_BIT];
	assign route_sel_hi         = txcs_r[ARC_ROUTE_HI_BIT];
	assign route_sel_lo         = txcs_r[ARC_ROUTE_LO_BIT];
	assign route_mode           = route_sel_hi ? ARC_ROUTE_DIN :
	                              route_sel_lo ? ARC_ROUTE_TX  : ARC_ROUTE_SERIAL2;
	assign dither_on            = dith_r[ARC_DITHER_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Restart beats step so every period begins at the programmed address.
	// The host keeps the address in range; nothing here clamps it.
	assign pc_nxt = sample_start ? start_r[PC_W-1:0] :
	                step         ? PC_W'(pc_r + 1'b1) : pc_r;

	always_ff @(posedge core_clk) begin
		if (reset)
			pc_r <= '0;
		else
			pc_r <= pc_nxt;
	end
	assign dsp_pc = pc_r;

	////////////////////////////////////////////////////////////////////////////
	property p_pc_load;
		@(posedge core_clk) disable iff (reset)
		sample_start |=> (dsp_pc == $past(start_r[PC_W-1:0]));
	endproperty
	a_pc_load: assert property (p_pc_load) else $error("pc not loaded");

	property p_pc_step;
		@(posedge core_clk) disable iff (reset)
		(!sample_start && step) |=> (dsp_pc == PC_W'($past(dsp_pc) + 1'b1));
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc did not advance");

	property p_unused_zero;
		@(posedge core_clk) disable iff (reset)
		((amux_r & ~ARC_MASK_AMUX) == '0) && ((txcs_r & ~ARC_MASK_TXCS) == '0) &&
		((dith_r & ~ARC_MASK_DITHER) == '0) && ((start_r & ~ARC_MASK_START) == '0);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

	property p_hi_sel;
		@(posedge core_clk) disable iff (reset)
		(wr_en && hit_amux && wr_data[27:24] == 4'h1) |=> hi_line_sel[0] && !hi_mute;
	endproperty
	a_hi_sel: assert property (p_hi_sel) else $error("high select line 1 wrong");

	property p_lo_mute;
		@(posedge core_clk) disable iff (reset)
		(wr_en && hit_amux && wr_data[3:0] == ARC_SEL_MUTE) |=> lo_mute && (lo_line_sel == '0);
	endproperty
	a_lo_mute: assert property (p_lo_mute) else $error("low select not muted");

	property p_lo_dac;
		@(posedge core_clk) disable iff (reset)
		(wr_en && hit_amux && wr_data[3:0] == ARC_SEL_DAC) |=> lo_dac_sel && !lo_rsv;
	endproperty
	a_lo_dac: assert property (p_lo_dac) else $error("low DAC path not selected");

	property p_copy;
		@(posedge core_clk) disable iff (reset)
		(wr_en && hit_txcs) |=> (copy_permit == $past(wr_data[31])) &&
		                        (emphasis_flag == $past(wr_data[30]));
	endproperty
	a_copy: assert property (p_copy) else $error("copy or emphasis wrong");

	property p_cs_len;
		@(posedge core_clk) disable iff (reset)
		(wr_en && hit_txcs) |=> (sample_length_field == $past(wr_data[27:24])) &&
		  (sample_rate_field == $past(wr_data[23:22]));
	endproperty
	a_cs_len: assert property (p_cs_len) else $error("cs length wrong");

	property p_cs_val;
		@(posedge core_clk) disable iff (reset)
		(wr_en && hit_txcs) |=> (left_valid_flag == $past(wr_data[21])) &&
		  (right_valid_flag == $past(wr_data[20])) &&
		  (source_number_field == $past(wr_data[19:16]));
	endproperty
	a_cs_val: assert property (p_cs_val) else $error("cs valid wrong");

	property p_cs_cat;
		@(posedge core_clk) disable iff (reset)
		(wr_en && hit_txcs) |=> (category_code == $past(wr_data[15:9])) &&
		  (generation_flag == $past(wr_data[8]));
	endproperty
	a_cs_cat: assert property (p_cs_cat) else $error("cs category wrong");

	property p_route;
		@(posedge core_clk) disable iff (reset)
		(wr_en && hit_txcs && wr_data[1:0] == 2'h1) |=> (route_mode == ARC_ROUTE_TX);
	endproperty
	a_route: assert property (p_route) else $error("route not transmitter");

	property p_route_din;
		@(posedge core_clk) disable iff (reset)
		route_sel_hi |-> (route_mode == ARC_ROUTE_DIN);
	endproperty
	a_route_din: assert property (p_route_din) else $error("route not input");

	property p_dither;
		@(posedge core_clk) disable iff (reset)
		// A back-to-back write may legally change the enable again
		(wr_en && hit_dith) |=> (dither_on == $past(wr_data[0])) ##1
		  ($past(wr_en && hit_dith) || (dither_on == $past(dither_on)));
	endproperty
	a_dither: assert property (p_dither) else $error("dither enable wrong");

	property p_read;
		@(posedge core_clk) disable iff (reset)
		(rd_en && !wr_en && hit_start) |=> rd_valid && (rd_data == $past(start_r));
	endproperty
	a_read: assert property (p_read) else $error("read data wrong");

	c_restart: cover property (@(posedge core_clk) disable iff (reset) step ##1 sample_start);
	c_din:     cover property (@(posedge core_clk) disable iff (reset) route_mode == ARC_ROUTE_DIN);
	c_hi_rsv:  cover property (@(posedge core_clk) disable iff (reset) hi_rsv);
	c_dither:  cover property (@(posedge core_clk) disable iff (reset) $rose(dither_on));
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the audio routing register bank
// Assumes: Host model drives the control port at the falling edge
// Notes:   Fixed seed keeps every run identical
`timescale 1ns/1ps
module tb_top
	import arc_pkg::*;
;
	logic                  core_clk     = 1'b0;
	logic                  reset        = 1'b1;
	logic                  sample_start = 1'b0;
	logic                  step         = 1'b0;
	logic                  wr_en, rd_en, rd_valid, ok;
	logic [7:0]            addr;
	logic [31:0]           wr_data, rd_data, rd, d;
	logic [11:0]           dsp_pc;
	logic [9:0]            hi_line_sel, lo_line_sel;
	logic                  hi_mute, hi_dac_sel, lo_mute, lo_dac_sel, copy_permit;
	logic                  emphasis_flag, left_valid_flag, right_valid_flag;
	logic                  generation_flag, route_sel_hi, route_sel_lo, dither_on;
	logic [1:0]            clock_accuracy_field, sample_rate_field;
	logic [3:0]            sample_length_field, source_number_field;
	logic [6:0]            category_code;
	arc_route_type         route_mode, rt;
	int                    fail_count = 0;
	int                    n_compared = 0;
	int                    seed       = 32'h286d;
	int                    cycles     = 0;
	logic [7:0]            ofs [4] = '{ARC_OFS_AMUX, ARC_OFS_TXCS, ARC_OFS_DITHER, ARC_OFS_START};
	logic [31:0]           msk [4] = '{ARC_MASK_AMUX, ARC_MASK_TXCS, ARC_MASK_DITHER, ARC_MASK_START};
	wire  [31:0]           tx_view = {copy_permit, emphasis_flag, clock_accuracy_field,
		sample_length_field, sample_rate_field, left_valid_flag, right_valid_flag,
		source_number_field, category_code, generation_flag, 6'h00, route_sel_hi, route_sel_lo};

	arc_regs #(.PC_W(ARC_PC_W)) DUT (
		.core_clk, .reset, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_valid,
		.sample_start, .step, .dsp_pc, .hi_line_sel, .hi_mute, .hi_dac_sel,
		.lo_line_sel, .lo_mute, .lo_dac_sel, .copy_permit, .emphasis_flag,
		.clock_accuracy_field, .sample_length_field, .sample_rate_field, .left_valid_flag,
		.right_valid_flag, .source_number_field, .category_code, .generation_flag,
		.route_sel_hi, .route_sel_lo, .route_mode, .dither_on
	);
	arc_host u_host (.core_clk, .rd_data, .rd_valid, .wr_en, .rd_en, .addr, .wr_data);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [11:0] exp_sel(input logic [3:0] c);
		logic [11:0] r;
		r = 12'h000;
		if (c == 4'h0)
			r[10] = 1'b1;
		else if (c == 4'hB)
			r[11] = 1'b1;
		else if (c <= 4'hA)
			r[c - 4'h1] = 1'b1;
		return r;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		u_host.read(a, rd, ok);
		chk("rd_valid", 32'h0000_0001, 32'(ok));
		chk("rd_data", e, rd);
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always #20 core_clk = ~core_clk;
	// A hang costs a mismatch rather than a silent stall
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			print_verdict();
		end
	end

	initial begin
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'b0;
		chk("hi_mute", 32'h0000_0001, 32'(hi_mute));
		chk("route_mode", 32'(ARC_ROUTE_SERIAL2), 32'(route_mode));
		for (int i = 0; i < 4; i++) begin
			rdchk(ofs[i], 32'h0000_0000);
			d = $random(seed);
			if (i == 3)
				d[11] = 1'b0;
			u_host.write(ofs[i], d);
			rdchk(ofs[i], d & msk[i]);
		end
		$display("test readback done");
		for (int c = 0; c < 16; c++) begin
			d = $random(seed);
			d[27:24] = 4'(15 - c);
			d[3:0] = 4'(c);
			u_host.write(ARC_OFS_AMUX, d);
			chk("hi_sel", 32'(exp_sel(d[27:24])), 32'({hi_dac_sel, hi_mute, hi_line_sel}));
			chk("lo_sel", 32'(exp_sel(d[3:0])), 32'({lo_dac_sel, lo_mute, lo_line_sel}));
		end
		$display("test input select done");
		for (int i = 0; i < 24; i++) begin
			d = $random(seed);
			d[1:0] = 2'(i);
			if (i == 0)
				d = 32'h0000_0000;
			if (i == 1)
				d = 32'hFFFF_FFFF;
			if (i == 2)
				d = 32'h0042_5401;
			u_host.write(ARC_OFS_TXCS, d);
			chk("tx_flags", 32'(d[31:24]), 32'(tx_view[31:24]));
			chk("tx_rate", 32'(d[23:16]), 32'(tx_view[23:16]));
			chk("tx_cat", 32'(d[15:8]), 32'(tx_view[15:8]));
			chk("tx_low", 32'(d[7:0] & ARC_MASK_TXCS[7:0]), 32'(tx_view[7:0]));
			rt = d[1] ? ARC_ROUTE_DIN : d[0] ? ARC_ROUTE_TX : ARC_ROUTE_SERIAL2;
			chk("route_mode", 32'(rt), 32'(route_mode));
		end
		$display("test channel status done");
		for (int i = 0; i < 4; i++) begin
			d = i[1] ? 32'hFFFF_FFFE : 32'h0000_0000;
			d[0] = i[0];
			u_host.write(ARC_OFS_DITHER, d);
			chk("dither_on", 32'(d[0]), 32'(dither_on));
		end
		// Unmapped place must neither answer data nor disturb mapped state
		u_host.write(8'h13, 32'h0000_0000);
		chk("dither_on", 32'h0000_0001, 32'(dither_on));
		rdchk(8'h13, 32'h0000_0000);
		$display("test dither done");
		for (int k = 0; k < 6; k++) begin
			d = 32'($unsigned($random(seed)) % 3328);
			if (k == 0)
				d = 32'(ARC_PC_LAST);
			u_host.write(ARC_OFS_START, d | 32'hFFFF_F000);
			@(negedge core_clk);
			sample_start = 1'b1;
			step = k[0];
			@(negedge core_clk);
			sample_start = 1'b0;
			chk("dsp_pc", d, 32'(dsp_pc));
			step = 1'b1;
			repeat (k + 1) @(negedge core_clk);
			chk("dsp_pc_run", 32'(d[11:0] + 12'(k + 1)), 32'(dsp_pc));
			// Restart while still stepping: the period start must win
			sample_start = 1'b1;
			@(negedge core_clk);
			sample_start = 1'b0;
			step = 1'b0;
			chk("dsp_pc_restart", d, 32'(dsp_pc));
		end
		$display("test program restart done");
		print_verdict();
	end
endmodule
